// >>> tcc_pkg.sv
// package for trigger and completion control: codes, limits, timing
// assumes a single 100 MHz system clock
package tcc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int DONE_PULSE_US  = 1000;
    localparam int DONE_PULSE_CYC = DONE_PULSE_US * CLK_MHZ;
    localparam int LOCKOUT_S      = 5;
    localparam int LOCKOUT_CYC    = LOCKOUT_S * 1000000 * CLK_MHZ;

    // ------------------------------------------------------------
    // address codes
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_MAX_NORMAL = 6'h1E;
    localparam logic [5:0] CODE_PRINT_A    = 6'h28;
    localparam logic [5:0] CODE_PRINT_B    = 6'h29;
    localparam logic [5:0] CODE_PLOT_FWD   = 6'h2A;
    localparam logic [5:0] CODE_PLOT_REV   = 6'h2B;
    localparam logic [5:0] ADDR_RESET      = 6'h1C;

    // ------------------------------------------------------------
    // y-axis limits, tenths of a volt, sign separate
    // ------------------------------------------------------------
    localparam logic [4:0]  YLIM_MIN        = 5'h01;
    localparam logic [4:0]  YLIM_MAX        = 5'h14;
    localparam logic [4:0]  YLIM_RESET      = 5'h14;
    localparam logic [15:0] COUNTS_PER_STEP = 16'h03E8;

    typedef enum logic [1:0] {
        TCC_ADDR_NORMAL,
        TCC_ADDR_PRINTER,
        TCC_ADDR_PLOTTER,
        TCC_ADDR_INVALID
    } tcc_addr_kind_e;

endpackage

// >>> tcc_trigger_ctrl.sv
// trigger and completion control for a bench instrument
// assumes trigger input synchronous-or-not, one 100 MHz clock, nrst reset
`timescale 1ns/1ps

module tcc_trigger_ctrl
    import tcc_pkg::*;
#(
    parameter int LOCK_CYC = LOCKOUT_CYC
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        ext_trigger_mode_setting_n,
    input  wire logic        panel_trigger_mode_setting,
    input  wire logic        continuous_external_trigger_cmd,
    input  wire logic        one_shot_external_trigger_cmd,
    input  wire logic        trigger_mode_setting_toggle,
    input  wire logic        reading_done,
    input  wire logic        panel_btn,
    input  wire logic [5:0]  addr_set_val,
    input  wire logic        addr_set_we,
    input  wire logic [4:0]  y_limit_val,
    input  wire logic        y_limit_neg,
    input  wire logic        y_upper_we,
    input  wire logic        y_lower_we,
    input  wire logic        grid_req,
    input  wire logic        grid_busy,
    input  wire logic        plotter_ack,
    input  wire logic        bus_sending,
    input  wire logic        other_ctrl_active,
    output logic             start_reading,
    output logic             one_shot_mode,
    output logic             trigger_overrun_indication,
    output logic             meter_done_n,
    output logic [5:0]       bus_addr,
    output logic [1:0]       addr_kind,
    output logic             ctrl_active,
    output logic             x_reverse,
    output logic             plot_params_en,
    output logic [4:0]       y_axis_upper_limit,
    output logic             y_axis_upper_neg,
    output logic [4:0]       y_axis_lower_limit,
    output logic             y_axis_lower_neg,
    output logic [15:0]      y_upper_counts,
    output logic             panel_btn_ok
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic tcc_addr_kind_e kind_of(input logic [5:0] a);
        if (a <= ADDR_MAX_NORMAL)
            kind_of = TCC_ADDR_NORMAL;
        else if (a == CODE_PRINT_A || a == CODE_PRINT_B)
            kind_of = TCC_ADDR_PRINTER;
        else if (a == CODE_PLOT_FWD || a == CODE_PLOT_REV)
            kind_of = TCC_ADDR_PLOTTER;
        else
            kind_of = TCC_ADDR_INVALID;
    endfunction

    function automatic logic ylim_ok(input logic [4:0] v);
        ylim_ok = (v >= YLIM_MIN) && (v <= YLIM_MAX);
    endfunction

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    typedef enum {TCC_IDLE, TCC_RUN} tcc_state_e;

    tcc_state_e  state_ff;
    tcc_state_e  nxt_state;
    logic        sync1_ff;
    logic        sync2_ff;
    logic        sync3_ff;
    logic        mode_ff;
    logic        run_ff;
    logic        done_ff;
    logic [31:0] pulse_cnt_ff;
    logic [31:0] lock_cnt_ff;
    logic        lock_ff;
    logic [5:0]  addr_ff;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire         trigger_mode_setting_fall   = sync3_ff & ~sync2_ff;
    wire         lock_active = lock_ff | grid_busy;
    wire         panel_ok    = panel_trigger_mode_setting & ~lock_active;
    wire         any_trigger_mode_setting    = trigger_mode_setting_fall | panel_ok;
    wire         busy        = (state_ff == TCC_RUN);
    wire         accept      = any_trigger_mode_setting & ~busy;
    wire         overrun     = any_trigger_mode_setting & busy;
    wire         kind_plot   = kind_of(addr_ff) == TCC_ADDR_PLOTTER;
    wire         plot_we_ok  = kind_plot & ylim_ok(y_limit_val);
    wire         addr_ok     = kind_of(addr_set_val) != TCC_ADDR_INVALID;
    wire         nxt_mode    = one_shot_external_trigger_cmd ? 1'b1 :
                               continuous_external_trigger_cmd ? 1'b0 :
                               trigger_mode_setting_toggle ? ~mode_ff :
                               mode_ff;
    wire         mode_to_cont = mode_ff & ~nxt_mode;
    wire         nxt_run     = mode_to_cont ? 1'b0 :
                               accept ? ~nxt_mode : run_ff;
    wire         restart     = run_ff & ~mode_ff & done_ff & ~busy;
    wire         go          = accept | (restart & ~mode_to_cont);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            TCC_IDLE: begin
                if (go)
                    nxt_state = TCC_RUN;
            end
            TCC_RUN: begin
                if (reading_done)
                    nxt_state = TCC_IDLE;
            end
            default: nxt_state = TCC_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // trigger synchroniser and sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            sync3_ff <= 1'b1;
        end else begin
            sync1_ff <= ext_trigger_mode_setting_n;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff      <= TCC_IDLE;
            mode_ff       <= 1'b0;
            run_ff        <= 1'b0;
            start_reading <= 1'b0;
            one_shot_mode <= 1'b0;
            trigger_overrun_indication <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            mode_ff       <= nxt_mode;
            run_ff        <= nxt_run;
            start_reading <= go & (state_ff == TCC_IDLE);
            one_shot_mode <= nxt_mode;
            if (overrun)
                trigger_overrun_indication <= 1'b1;
            else if (accept)
                trigger_overrun_indication <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // completion pulse
    // ------------------------------------------------------------
    wire done_evt = busy & reading_done;

    // remembers the finished reading so continuous mode restarts from idle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            done_ff <= 1'b0;
        else
            done_ff <= done_evt;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pulse_cnt_ff <= '0;
            meter_done_n <= 1'b1;
        end else if (done_evt) begin
            pulse_cnt_ff <= 32'(DONE_PULSE_CYC);
            meter_done_n <= 1'b0;
        end else if (pulse_cnt_ff != '0) begin
            pulse_cnt_ff <= pulse_cnt_ff - 32'd1;
            meter_done_n <= (pulse_cnt_ff == 32'd1);
        end
    end

    // ------------------------------------------------------------
    // address and plotter settings
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            addr_ff        <= ADDR_RESET;
            bus_addr       <= ADDR_RESET;
            addr_kind      <= TCC_ADDR_NORMAL;
            x_reverse      <= 1'b0;
            plot_params_en <= 1'b0;
            ctrl_active    <= 1'b0;
        end else begin
            if (addr_set_we && addr_ok)
                addr_ff <= addr_set_val;
            bus_addr       <= addr_ff;
            addr_kind      <= kind_of(addr_ff);
            x_reverse      <= (addr_ff == CODE_PLOT_REV);
            plot_params_en <= kind_plot;
            ctrl_active    <= bus_sending & ~other_ctrl_active &
                              (kind_of(addr_ff) == TCC_ADDR_PRINTER ||
                               kind_plot);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            y_axis_upper_limit <= YLIM_RESET;
            y_axis_upper_neg   <= 1'b0;
            y_axis_lower_limit <= YLIM_RESET;
            y_axis_lower_neg   <= 1'b1;
            y_upper_counts     <= 16'h4E20;
        end else begin
            if (y_upper_we && plot_we_ok) begin
                y_axis_upper_limit <= y_limit_val;
                y_axis_upper_neg   <= y_limit_neg;
            end
            if (y_lower_we && plot_we_ok) begin
                y_axis_lower_limit <= y_limit_val;
                y_axis_lower_neg   <= y_limit_neg;
            end
            y_upper_counts <= 16'(y_axis_upper_limit * COUNTS_PER_STEP);
        end
    end

    // ------------------------------------------------------------
    // grid lockout
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lock_ff      <= 1'b0;
            lock_cnt_ff  <= '0;
            panel_btn_ok <= 1'b0;
        end else begin
            if (grid_req && kind_plot && !plotter_ack && !lock_ff) begin
                lock_ff     <= 1'b1;
                lock_cnt_ff <= 32'(LOCK_CYC);
            end else if (lock_ff) begin
                if (plotter_ack || lock_cnt_ff <= 32'd1)
                    lock_ff <= 1'b0;
                lock_cnt_ff <= lock_cnt_ff - 32'd1;
            end
            panel_btn_ok <= panel_btn & ~lock_active;
        end
    end

endmodule

// >>> tcc_far_model.sv
// far side: trigger source, reading engine, downstream instrument
// assumes the bench calls fire() at 1 ns after a rising clock edge
`timescale 1ns/1ps

module tcc_far_model (
    input  wire logic clock,
    input  wire logic start_reading,
    input  wire logic meter_done_n,
    output logic      ext_trigger_mode_setting_n,
    output logic      reading_done
);
    // bus address constant; nothing in this model uses it, and it decodes as a normal address
    localparam int PLOTTER_ADDR = 5;
    int lat   = 8;
    int falls = 0;
    initial begin
        ext_trigger_mode_setting_n   = 1'b1;
        reading_done = 1'b0;
    end
    // ------------------------------------------------------------
    // trigger pulse held low for width cycles, idle high (pull-up)
    // ------------------------------------------------------------
    task automatic fire(input int width);
        ext_trigger_mode_setting_n = 1'b0;
        repeat (width) @(posedge clock);
        #1 ext_trigger_mode_setting_n = 1'b1;
    endtask
    // engine answers each start after lat cycles
    always @(posedge clock) begin
        if (start_reading === 1'b1) begin
            repeat (lat) @(posedge clock);
            #1 reading_done = 1'b1;
            @(posedge clock);
            #1 reading_done = 1'b0;
        end
    end
    // downstream instrument counts completion pulses
    always @(negedge meter_done_n) falls++;
endmodule

// >>> tcc_trigger_ctrl_props.sv
// assertions on the ports of the trigger and completion block
// assumes one clock domain and bind onto tcc_trigger_ctrl
`timescale 1ns/1ps

module tcc_trigger_ctrl_props
    import tcc_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        one_shot_external_trigger_cmd,
    input wire logic        reading_done,
    input wire logic [5:0]  addr_set_val,
    input wire logic        addr_set_we,
    input wire logic        grid_busy,
    input wire logic        one_shot_mode,
    input wire logic        meter_done_n,
    input wire logic        x_reverse,
    input wire logic        plot_params_en,
    input wire logic [4:0]  y_axis_upper_limit,
    input wire logic [15:0] y_upper_counts,
    input wire logic        panel_btn_ok
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // low time of the completion output
    // ------------------------------------------------------------
    int low_cnt_ff;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) low_cnt_ff <= 0;
        else low_cnt_ff <= meter_done_n ? 0 : low_cnt_ff + 1;
    end
    property p_rst_mode; $rose(nrst) |-> !one_shot_mode; endproperty
    a_rst_mode: assert property (p_rst_mode) else $error("bad mode");
    property p_done; reading_done |=> !meter_done_n; endproperty
    a_done: assert property (p_done) else $error("no pulse");
    property p_hold; $rose(meter_done_n) |-> low_cnt_ff >= DONE_PULSE_CYC;
    endproperty
    a_hold: assert property (p_hold) else $error("pulse short");
    property p_cause; $fell(meter_done_n) |-> $past(reading_done); endproperty
    a_cause: assert property (p_cause) else $error("stray pulse");
    property p_one; one_shot_external_trigger_cmd |=> one_shot_mode; endproperty
    a_one: assert property (p_one) else $error("no one-shot");
    property p_rev; addr_set_we && addr_set_val == CODE_PLOT_REV
        |-> ##[1:2] (x_reverse && plot_params_en); endproperty
    a_rev: assert property (p_rev) else $error("no reverse");
    property p_cnt; y_upper_counts ==
        ({11'h000, $past(y_axis_upper_limit)} * COUNTS_PER_STEP); endproperty
    a_cnt: assert property (p_cnt) else $error("bad counts");
    property p_btn; $past(grid_busy) |-> !panel_btn_ok; endproperty
    a_btn: assert property (p_btn) else $error("button live");
endmodule

bind tcc_trigger_ctrl tcc_trigger_ctrl_props u_props (.*);

// >>> tcc_trigger_ctrl_bench.sv
// self-checking bench for the trigger and completion block
// assumes tcc_far_model as trigger source and reading engine
`timescale 1ns/1ps

module tcc_trigger_ctrl_bench
    import tcc_pkg::*;
;
    logic clock, nrst, panel_trigger_mode_setting, continuous_external_trigger_cmd;
    logic one_shot_external_trigger_cmd, trigger_mode_setting_toggle;
    logic panel_btn, addr_set_we, y_limit_neg, y_upper_we, y_lower_we;
    logic grid_req, grid_busy, plotter_ack, bus_sending, other_ctrl_active;
    logic ext_trigger_mode_setting_n, reading_done, start_reading, one_shot_mode;
    logic trigger_overrun_indication, meter_done_n, ctrl_active, x_reverse;
    logic plot_params_en, y_axis_upper_neg, y_axis_lower_neg, panel_btn_ok;
    logic [5:0]  addr_set_val, bus_addr;
    logic [4:0]  y_limit_val, y_axis_upper_limit, y_axis_lower_limit;
    logic [1:0]  addr_kind;
    logic [15:0] y_upper_counts;
    int          err_count = 0, checks_done = 0, starts = 0, s0, k;
    localparam logic [5:0] ADDRS [6] = '{6'h00, ADDR_MAX_NORMAL,
        CODE_PRINT_A, CODE_PRINT_B, CODE_PLOT_REV, CODE_PLOT_FWD};
    localparam logic [3:0] KINDS [6] = '{4'h0, 4'h0, 4'h4, 4'h4, 4'hB, 4'h9};

    tcc_trigger_ctrl #(.LOCK_CYC(50)) u_dut (.*);
    tcc_far_model u_far (.*);

    always #5 clock = ~clock;
    always @(posedge clock) if (start_reading === 1'b1) starts++;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {clock, nrst, panel_trigger_mode_setting, continuous_external_trigger_cmd,
         one_shot_external_trigger_cmd, trigger_mode_setting_toggle,
         panel_btn, addr_set_we, y_limit_neg, y_upper_we, y_lower_we,
         grid_req, grid_busy, plotter_ack, bus_sending,
         other_ctrl_active} = '0;
        addr_set_val = 6'h00;
        y_limit_val = 5'h00;
        tick(16);
        nrst = 1'b1;
        chk({one_shot_mode, trigger_overrun_indication, meter_done_n}, 1);
        chk({bus_addr, y_axis_upper_limit, y_axis_lower_limit},
            {ADDR_RESET, YLIM_RESET, YLIM_RESET});
        chk({y_axis_upper_neg, y_axis_lower_neg, y_upper_counts},
            {2'b01, 16'h4E20});
        s0 = starts;
        u_far.fire(1000);
        chk(starts - s0 > 10, 1);
        chk(meter_done_n, 0);
        pulse(one_shot_external_trigger_cmd);
        tick(20);
        chk(one_shot_mode, 1);
        s0 = starts;
        u_far.fire(1000);
        tick(50);
        chk(starts - s0, 1);
        u_far.lat = 200;
        s0 = starts;
        pulse(panel_trigger_mode_setting);
        tick(5);
        pulse(panel_trigger_mode_setting);
        tick(300);
        chk(starts - s0, 1);
        chk(trigger_overrun_indication, 1);
        pulse(continuous_external_trigger_cmd);
        s0 = starts;
        tick(100);
        chk(one_shot_mode, 0);
        chk(starts - s0, 0);
        pulse(trigger_mode_setting_toggle);
        tick(2);
        chk(one_shot_mode, 1);
        for (k = 0; k < 6; k++) begin
            addr_set_val = ADDRS[k];
            pulse(addr_set_we);
            tick(2);
            chk({addr_kind, x_reverse, plot_params_en}, KINDS[k]);
        end
        addr_set_val = 6'h1F;
        pulse(addr_set_we);
        tick(2);
        chk(bus_addr, CODE_PLOT_FWD);
        y_limit_val = 5'h0A;
        pulse(y_upper_we);
        tick(3);
        chk({y_axis_upper_limit, y_upper_counts}, {5'h0A, 16'h2710});
        y_limit_val = 5'h15;
        pulse(y_upper_we);
        tick(3);
        chk(y_axis_upper_limit, 5'h0A);
        bus_sending = 1'b1;
        tick(3);
        chk(ctrl_active, 1);
        bus_sending = 1'b0;
        panel_btn = 1'b1;
        tick(3);
        chk(panel_btn_ok, 1);
        pulse(grid_req);
        tick(2);
        chk(panel_btn_ok, 0);
        tick(60);
        chk(panel_btn_ok, 1);
        grid_busy = 1'b1;
        tick(3);
        chk(panel_btn_ok, 0);
        grid_busy = 1'b0;
        addr_set_val = 6'h00;
        pulse(addr_set_we);
        y_limit_val = 5'h03;
        pulse(y_upper_we);
        tick(3);
        chk(y_axis_upper_limit, 5'h0A);
        k = 0;
        while (meter_done_n !== 1'b1 && k < 120000) begin
            tick(1);
            k++;
        end
        chk(k < 120000, 1);
        chk(u_far.falls, 1);
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        chk(y_axis_upper_limit, YLIM_RESET);
        final_report();
    end
endmodule
